// *** gibs_defs.svh ***
// register map, field positions and reset values of the irq/boot status
// block; included by the package and the design modules.
`ifndef GIBS_DEFS_SVH
`define GIBS_DEFS_SVH
`define GIBS_ADDR_W 16
`define GIBS_ADDR_IRQ_STATUS 16'h0200
`define GIBS_ADDR_IRQ_ENABLE 16'h0208
`define GIBS_ADDR_SUMMARY 16'h020D
`define GIBS_ADDR_RSVD_A 16'h020E
`define GIBS_ADDR_RSVD_B 16'h020F
`define GIBS_ADDR_BOOT_ERR 16'h0210
`define GIBS_ADDR_BOOT_DONE 16'h0211
`define GIBS_ADDR_RSVD_C 16'h0212
`define GIBS_BIT_LOS0 0
`define GIBS_BIT_LOS1 1
`define GIBS_BIT_HOLD 4
`define GIBS_BIT_LOL 6
`define GIBS_BIT_SUMMARY 0
`define GIBS_BIT_FAIL 0
`define GIBS_BIT_CRC 1
`define GIBS_BIT_DONE 0
`define GIBS_ALARM_MASK 8'h53
`define GIBS_BYTE_ZERO 8'h00
`endif

// *** gibs_pkg.sv ***
// types shared by the irq/boot status block
// assumes gibs_defs.svh is on the include path
`include "gibs_defs.svh"
package gibs_pkg;
   typedef logic [7:0] gibs_byte_t;
   typedef logic [`GIBS_ADDR_W-1:0] gibs_addr_t;
endpackage

// *** gibs_boot_flags.sv ***
// boot-load outcome flags: set by the loader, cleared only by reset
// assumes loader strobes are single-cycle pulses on clk
`timescale 1ns/1ps
`default_nettype none
`include "gibs_defs.svh"
module gibs_boot_flags
(
   input wire logic clk, // control clock
   input wire logic resetn, // async reset, active low
   input wire logic load_done_pulse, // loader finished read cycle
   input wire logic load_fail_pulse, // loader read failed
   input wire logic load_crc_pulse, // loader checksum mismatch
   output logic boot_load_complete, // sticky done flag
   output logic boot_load_failed, // sticky read failure flag
   output logic boot_crc_error // sticky crc mismatch flag
);
   logic next_complete;
   logic next_failed;
   logic next_crc;

   always_comb
   begin
      next_complete = boot_load_complete | load_done_pulse;
      next_failed = boot_load_failed | load_fail_pulse;
      next_crc = boot_crc_error | load_crc_pulse;
   end

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         boot_load_complete <= 1'h0;
         boot_load_failed <= 1'h0;
         boot_crc_error <= 1'h0;
      end
      else
      begin
         boot_load_complete <= next_complete;
         boot_load_failed <= next_failed;
         boot_crc_error <= next_crc;
      end
   end

   chk_crc_held: assert property (
      @(posedge clk) disable iff (!resetn)
      $past(boot_crc_error) |-> boot_crc_error)
      else $error("crc flag dropped without reset");
   chk_fail_held: assert property (
      @(posedge clk) disable iff (!resetn)
      load_fail_pulse |=> boot_load_failed [*3])
      else $error("fail flag not set and held");
   chk_done_held: assert property (
      @(posedge clk) disable iff (!resetn)
      boot_load_complete |=> boot_load_complete)
      else $error("done flag dropped without reset");
endmodule
`default_nettype wire

// *** gibs_irq_status.sv ***
// global interrupt summary and boot status registers of the clock device
// assumes a serial-port register engine on clk with one-cycle write and
// read strobes, alarm and loader event pulses synchronous to clk
`timescale 1ns/1ps
`default_nettype none
`include "gibs_defs.svh"
// Notes on behaviour
// - enabled asserted status sets summary, pin low
// - nothing enabled asserted: summary zero, pin released
// - crc mismatch flag, cleared by reset only
// - read failure flag, held until reset
// - load complete flag, cleared by reset only
// - alarm status sticky, write one clears
// - disabled status never reaches the pin
module gibs_irq_status
(
   input wire logic clk, // control clock, 100 MHz
   input wire logic resetn, // async reset, active low
   input wire logic reg_wr, // register write strobe
   input wire logic reg_rd, // register read strobe
   input wire gibs_pkg::gibs_addr_t reg_addr, // register address
   input wire gibs_pkg::gibs_byte_t reg_wdata, // write data
   output gibs_pkg::gibs_byte_t reg_rdata, // read data, registered
   input wire logic lock_loss_alarm, // pll lost lock, pulse or level
   input wire logic holdover_alarm, // entered holdover
   input wire logic [1:0] signal_loss_alarm, // loss of signal per ref
   input wire logic load_done_pulse, // eeprom read cycle finished
   input wire logic load_fail_pulse, // eeprom read failed
   input wire logic load_crc_pulse, // eeprom checksum mismatch
   output logic irq_summary, // summary bit as read
   output logic irq_out_i, // open-drain pin input, unused level
   output logic irq_out_n_o, // pin output level, always 0
   output logic irq_out_n_oe // high while pulling the pin low
);
   logic lock_loss_sticky;
   logic holdover_sticky;
   logic [1:0] signal_loss_sticky_ref;
   logic lock_loss_irq_enable;
   logic holdover_irq_enable;
   logic [1:0] signal_loss_irq_enable;
   logic next_lock_loss_sticky;
   logic next_holdover_sticky;
   logic [1:0] next_signal_loss_sticky_ref;
   logic next_lock_loss_irq_enable;
   logic next_holdover_irq_enable;
   logic [1:0] next_signal_loss_irq_enable;
   gibs_pkg::gibs_byte_t next_reg_rdata;
   gibs_pkg::gibs_byte_t alarm_byte;
   gibs_pkg::gibs_byte_t enable_byte;
   logic boot_load_complete;
   logic boot_load_failed;
   logic boot_crc_error;
   logic wr_status;
   logic wr_enable;

   // pack four alarm bits into their byte positions
   function automatic gibs_pkg::gibs_byte_t pack_alarms(input logic lol,
      input logic hold, input logic [1:0] los);
      gibs_pkg::gibs_byte_t b;
      b = `GIBS_BYTE_ZERO;
      b[`GIBS_BIT_LOL] = lol;
      b[`GIBS_BIT_HOLD] = hold;
      b[`GIBS_BIT_LOS1] = los[1];
      b[`GIBS_BIT_LOS0] = los[0];
      return b;
   endfunction

   gibs_boot_flags u_boot_flags
   (
      .clk(clk),
      .resetn(resetn),
      .load_done_pulse(load_done_pulse),
      .load_fail_pulse(load_fail_pulse),
      .load_crc_pulse(load_crc_pulse),
      .boot_load_complete(boot_load_complete),
      .boot_load_failed(boot_load_failed),
      .boot_crc_error(boot_crc_error)
   );

   assign alarm_byte = pack_alarms(lock_loss_sticky, holdover_sticky,
      signal_loss_sticky_ref);
   assign enable_byte = pack_alarms(lock_loss_irq_enable,
      holdover_irq_enable, signal_loss_irq_enable);
   assign wr_status = reg_wr && (reg_addr == `GIBS_ADDR_IRQ_STATUS);
   assign wr_enable = reg_wr && (reg_addr == `GIBS_ADDR_IRQ_ENABLE);

   // no storage here so the pin follows status within the same cycle
   assign irq_summary = |(alarm_byte & enable_byte);
   assign irq_out_n_o = 1'h0;
   assign irq_out_n_oe = irq_summary;
   assign irq_out_i = 1'h0;

   always_comb
   begin
      // set wins over a write-one-to-clear in the same cycle
      next_lock_loss_sticky = lock_loss_alarm | (lock_loss_sticky &
         ~(wr_status & reg_wdata[`GIBS_BIT_LOL]));
      next_holdover_sticky = holdover_alarm | (holdover_sticky &
         ~(wr_status & reg_wdata[`GIBS_BIT_HOLD]));
      next_signal_loss_sticky_ref = signal_loss_alarm |
         (signal_loss_sticky_ref & ~({2{wr_status}} &
         {reg_wdata[`GIBS_BIT_LOS1], reg_wdata[`GIBS_BIT_LOS0]}));
      next_lock_loss_irq_enable = lock_loss_irq_enable;
      next_holdover_irq_enable = holdover_irq_enable;
      next_signal_loss_irq_enable = signal_loss_irq_enable;
      if (wr_enable)
      begin
         next_lock_loss_irq_enable = reg_wdata[`GIBS_BIT_LOL];
         next_holdover_irq_enable = reg_wdata[`GIBS_BIT_HOLD];
         next_signal_loss_irq_enable = {reg_wdata[`GIBS_BIT_LOS1],
            reg_wdata[`GIBS_BIT_LOS0]};
      end
   end

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         lock_loss_sticky <= 1'h0;
         holdover_sticky <= 1'h0;
         signal_loss_sticky_ref <= 2'h0;
         lock_loss_irq_enable <= 1'h0;
         holdover_irq_enable <= 1'h0;
         signal_loss_irq_enable <= 2'h0;
      end
      else
      begin
         lock_loss_sticky <= next_lock_loss_sticky;
         holdover_sticky <= next_holdover_sticky;
         signal_loss_sticky_ref <= next_signal_loss_sticky_ref;
         lock_loss_irq_enable <= next_lock_loss_irq_enable;
         holdover_irq_enable <= next_holdover_irq_enable;
         signal_loss_irq_enable <= next_signal_loss_irq_enable;
      end
   end

   // reserved bits read zero; writes to them are ignored
   always_comb
   begin
      next_reg_rdata = reg_rdata;
      if (reg_rd)
      begin
         next_reg_rdata = `GIBS_BYTE_ZERO;
         unique case (reg_addr)
            `GIBS_ADDR_IRQ_STATUS: next_reg_rdata = alarm_byte;
            `GIBS_ADDR_IRQ_ENABLE: next_reg_rdata = enable_byte;
            `GIBS_ADDR_SUMMARY:
               next_reg_rdata[`GIBS_BIT_SUMMARY] = irq_summary;
            `GIBS_ADDR_BOOT_ERR:
            begin
               next_reg_rdata[`GIBS_BIT_CRC] = boot_crc_error;
               next_reg_rdata[`GIBS_BIT_FAIL] = boot_load_failed;
            end
            `GIBS_ADDR_BOOT_DONE:
               next_reg_rdata[`GIBS_BIT_DONE] = boot_load_complete;
            default: next_reg_rdata = `GIBS_BYTE_ZERO;
         endcase
      end
   end

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         reg_rdata <= `GIBS_BYTE_ZERO;
      else
         reg_rdata <= next_reg_rdata;
   end

   // expectations spelled from single bits, not from the packed bytes, except chk_mask_gate and chk_enable_keep, which use enable_byte
   chk_pin_follows: assert property (
      @(posedge clk) disable iff (!resetn)
      irq_out_n_oe == ((lock_loss_sticky && lock_loss_irq_enable) ||
      (holdover_sticky && holdover_irq_enable) ||
      |(signal_loss_sticky_ref & signal_loss_irq_enable)))
      else $error("pin drive differs from enabled status");
   chk_pin_level: assert property (
      @(posedge clk) disable iff (!resetn)
      irq_out_n_oe |-> (irq_out_n_o == 1'h0) && irq_summary)
      else $error("pin driven high or summary clear");
   chk_pin_release: assert property (
      @(posedge clk) disable iff (!resetn)
      !(lock_loss_sticky && lock_loss_irq_enable) &&
      !(holdover_sticky && holdover_irq_enable) &&
      ((signal_loss_sticky_ref & signal_loss_irq_enable) == 2'h0)
      |-> !irq_summary && !irq_out_n_oe)
      else $error("summary set with no enabled status");
   chk_sticky_hold: assert property (
      @(posedge clk) disable iff (!resetn)
      (lock_loss_alarm || (lock_loss_sticky &&
      !(wr_status && reg_wdata[`GIBS_BIT_LOL]))) |=> lock_loss_sticky)
      else $error("lock loss status not held");
   chk_hold_set: assert property (
      @(posedge clk) disable iff (!resetn)
      holdover_alarm |=> holdover_sticky)
      else $error("holdover status not set");
   chk_los_set: assert property (
      @(posedge clk) disable iff (!resetn)
      signal_loss_alarm[1] |=> signal_loss_sticky_ref[1])
      else $error("loss of signal status not set");
   chk_w1c_clear: assert property (
      @(posedge clk) disable iff (!resetn)
      (wr_status && reg_wdata[`GIBS_BIT_HOLD] && !holdover_alarm)
      |=> !holdover_sticky)
      else $error("holdover status not cleared by write one");
   chk_mask_gate: assert property (
      @(posedge clk) disable iff (!resetn)
      (enable_byte == `GIBS_BYTE_ZERO) |-> !irq_out_n_oe)
      else $error("disabled status reached pin");
   chk_enable_write: assert property (
      @(posedge clk) disable iff (!resetn)
      wr_enable |=> (lock_loss_irq_enable ==
      $past(reg_wdata[`GIBS_BIT_LOL])) && (holdover_irq_enable ==
      $past(reg_wdata[`GIBS_BIT_HOLD])))
      else $error("enable write not taken");
   chk_enable_keep: assert property (
      @(posedge clk) disable iff (!resetn)
      !wr_enable |=> $stable(enable_byte))
      else $error("enable changed without a write");
   chk_read_summary: assert property (
      @(posedge clk) disable iff (!resetn)
      (reg_rd && reg_addr == `GIBS_ADDR_SUMMARY)
      |=> reg_rdata == {7'h00, $past(irq_summary)})
      else $error("summary read wrong");
   chk_boot_read: assert property (
      @(posedge clk) disable iff (!resetn)
      (reg_rd && reg_addr == `GIBS_ADDR_BOOT_ERR) |=> reg_rdata ==
      {6'h00, $past(boot_crc_error), $past(boot_load_failed)})
      else $error("boot error read wrong");
   chk_done_read: assert property (
      @(posedge clk) disable iff (!resetn)
      (reg_rd && reg_addr == `GIBS_ADDR_BOOT_DONE)
      |=> reg_rdata == {7'h00, $past(boot_load_complete)})
      else $error("boot done read wrong");
endmodule
`default_nettype wire

// *** gibs_host_pin.sv ***
// host side of the open-drain interrupt line, with its pull-up
// assumes the device only ever pulls the line low through its enable
`timescale 1ns/1ps
`default_nettype none
module gibs_host_pin
(
   input wire logic irq_out_n_o, // device pin level
   input wire logic irq_out_n_oe, // device pulls the line
   output logic irq_pin_n // wire level seen by the host
);
   // a released line rises to the pull-up, never keeps its last value
   assign irq_pin_n = irq_out_n_oe ? irq_out_n_o : 1'h1;
endmodule
`default_nettype wire

// *** global_irq_boot_status_tb_top.sv ***
// self-checking bench for the irq/boot status block
// assumes the design files and gibs_host_pin.sv are compiled first
`timescale 1ns/1ps
`default_nettype none
`include "gibs_defs.svh"
module global_irq_boot_status_tb_top;
   logic clk, resetn, reg_wr, reg_rd, lol, hold, ld, lf, lc;
   logic [1:0] los;
   gibs_pkg::gibs_addr_t reg_addr;
   gibs_pkg::gibs_byte_t reg_wdata, reg_rdata, st, en;
   logic irq_summary, irq_i, irq_o, irq_oe, irq_pin_n;
   int n_errors = 0;
   int checks_done = 0;
   gibs_irq_status dut_u (.clk(clk), .resetn(resetn), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata), .lock_loss_alarm(lol),
      .holdover_alarm(hold), .signal_loss_alarm(los),
      .load_done_pulse(ld), .load_fail_pulse(lf), .load_crc_pulse(lc),
      .irq_summary(irq_summary), .irq_out_i(irq_i),
      .irq_out_n_o(irq_o), .irq_out_n_oe(irq_oe));
   gibs_host_pin host_u (.irq_out_n_o(irq_o), .irq_out_n_oe(irq_oe),
      .irq_pin_n(irq_pin_n));
   function automatic gibs_pkg::gibs_byte_t alarm_bits();
      alarm_bits = {1'h0, lol, 1'h0, hold, 2'h0, los};
   endfunction
   task automatic chk(input gibs_pkg::gibs_byte_t got, exp);
      checks_done++;
      if (got !== exp)
         $display("wrong value at %0t: got %h exp %h", $time, got, exp);
      if (got !== exp)
         n_errors++;
   endtask
   task automatic wr(input gibs_pkg::gibs_addr_t ad,
      input gibs_pkg::gibs_byte_t d);
      @(negedge clk);
      reg_wr = 1'h1;
      reg_addr = ad;
      reg_wdata = d;
      @(negedge clk);
      reg_wr = 1'h0;
   endtask
   task automatic rd(input gibs_pkg::gibs_addr_t ad,
      input gibs_pkg::gibs_byte_t e);
      @(negedge clk);
      reg_rd = 1'h1;
      reg_addr = ad;
      @(negedge clk);
      reg_rd = 1'h0;
      chk(reg_rdata, e);
   endtask
   task automatic chk_irq;
      chk({7'h00, irq_summary}, {7'h00, |(st & en)});
      chk({7'h00, irq_pin_n}, {7'h00, ~|(st & en)});
      chk({7'h00, irq_i}, 8'h00);
   endtask
   task automatic pulse(input logic [2:0] v);
      @(negedge clk);
      {ld, lf, lc} = v;
      @(negedge clk);
      {ld, lf, lc} = 3'h0;
   endtask
   task automatic do_reset;
      resetn = 1'h0;
      repeat (16) @(negedge clk);
      resetn = 1'h1;
      st = 8'h00;
      en = 8'h00;
   endtask
   task automatic test_done;
      $display("checks %0d errors %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   initial
   begin
      clk = 1'h0;
      forever #5 clk = ~clk;
   end
   initial
   begin
      repeat (5000) @(posedge clk);
      n_errors++;
      $display("wrong value at %0t: watchdog expired", $time);
      test_done();
   end
   initial
   begin
      {reg_wr, reg_rd, lol, hold, ld, lf, lc, los} = 9'h000;
      reg_addr = 16'h0000;
      reg_wdata = 8'h00;
      void'($urandom(32'h5CD739DC));
      do_reset();
      for (int a = 16'h0208; a <= 16'h0212; a++)
         rd(a[15:0], 8'h00);
      rd(`GIBS_ADDR_IRQ_STATUS, 8'h00);
      $display("reset values done");
      for (int i = 0; i < 600; i++)
      begin
         {lol, hold, los} = 4'($urandom & $urandom & $urandom);
         reg_wr = ($urandom % 3) == 0;
         reg_addr = ($urandom % 2) ? `GIBS_ADDR_IRQ_ENABLE
            : `GIBS_ADDR_IRQ_STATUS;
         reg_wdata = 8'($urandom) & `GIBS_ALARM_MASK;
         @(negedge clk);
         // a clear in the same cycle as an alarm leaves the bit set
         if (reg_wr && reg_addr == `GIBS_ADDR_IRQ_STATUS)
            st = (st & ~reg_wdata) | alarm_bits();
         else
            st = st | alarm_bits();
         if (reg_wr && reg_addr == `GIBS_ADDR_IRQ_ENABLE)
            en = reg_wdata;
         chk_irq();
      end
      {reg_wr, lol, hold, los} = 5'h00;
      rd(`GIBS_ADDR_IRQ_STATUS, st);
      rd(`GIBS_ADDR_IRQ_ENABLE, en);
      rd(`GIBS_ADDR_SUMMARY, {7'h00, |(st & en)});
      wr(`GIBS_ADDR_IRQ_ENABLE, 8'h00);
      en = 8'h00;
      chk_irq();
      wr(`GIBS_ADDR_IRQ_STATUS, `GIBS_ALARM_MASK);
      st = 8'h00;
      wr(`GIBS_ADDR_IRQ_ENABLE, `GIBS_ALARM_MASK);
      en = `GIBS_ALARM_MASK;
      chk_irq();
      // corner: lock loss alarm still high while software clears it
      lol = 1'h1;
      wr(`GIBS_ADDR_IRQ_STATUS, 8'h40);
      lol = 1'h0;
      st = 8'h40;
      chk_irq();
      rd(`GIBS_ADDR_IRQ_STATUS, st);
      wr(`GIBS_ADDR_IRQ_STATUS, 8'h40);
      st = 8'h00;
      chk_irq();
      $display("interrupt summary done");
      pulse(3'h1);
      rd(`GIBS_ADDR_BOOT_ERR, 8'h02);
      pulse(3'h2);
      rd(`GIBS_ADDR_BOOT_ERR, 8'h03);
      rd(`GIBS_ADDR_BOOT_DONE, 8'h00);
      pulse(3'h4);
      wr(`GIBS_ADDR_BOOT_DONE, 8'h00);
      wr(`GIBS_ADDR_BOOT_ERR, 8'h00);
      rd(`GIBS_ADDR_BOOT_DONE, 8'h01);
      rd(`GIBS_ADDR_BOOT_ERR, 8'h03);
      do_reset();
      rd(`GIBS_ADDR_BOOT_ERR, 8'h00);
      rd(`GIBS_ADDR_BOOT_DONE, 8'h00);
      $display("boot flags done");
      test_done();
   end
endmodule
`default_nettype wire
